// ===== logic/cmp_pkg.sv
/*
  Shared constants and types for the comparator control block.
  Assumes a 32-bit AXI4-Lite register bus and an analog comparator outside.
*/
`default_nettype none
package cmp_pkg;
  // Bus address width and responses
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h9b;
  localparam logic [7:0] MUX_IDX = 8'h9f;
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] MUX_ADDR = {2'h0, MUX_IDX, 2'h0};

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MUX_RESET = 8'h00;

  // Control register fields
  localparam int EN_BIT = 7;
  localparam int OUT_BIT = 6;
  localparam int RISE_BIT = 5;
  localparam int FALL_BIT = 4;
  localparam int HYP_LSB = 2;
  localparam int HYN_LSB = 0;

  // Input select register fields
  localparam int NSEL_LSB = 4;
  localparam int PSEL_LSB = 0;

  // Pin synchroniser depth
  localparam int SYNC_DEPTH = 3;

  // Hysteresis settings: off, 5 mV, 10 mV, 20 mV
  typedef enum logic [1:0] {HYST_OFF, HYST_5MV, HYST_10MV, HYST_20MV} hyst_t;

  typedef enum logic [1:0] {SEL_CTRL, SEL_MUX, SEL_NONE} reg_sel_t;

  // Settings handed to the analog comparator
  typedef struct packed {
    logic enable;
    hyst_t pos_hyst;
    hyst_t neg_hyst;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
  } analog_cfg_t;
endpackage
`default_nettype wire

// ===== logic/cmp_sync.sv
/*
  Three-stage synchroniser for the comparator decision pin.
  Assumes the input is asynchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cmp_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and filtered level
  input wire logic async_in,
  output logic level
);
  typedef struct packed {
    logic [cmp_pkg::SYNC_DEPTH-1:0] stage;
    logic level;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.stage = {st_r.stage[1:0], async_in};
    // Only the second and third stages vote; the first may be metastable
    if (st_r.stage[1] == st_r.stage[2]) begin
      st_nxt.level = st_r.stage[2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.level;

  level_vote_a: assert property (@(posedge clk) disable iff (rst)
    $changed(st_r.level) |-> $past(st_r.stage[1]) == $past(st_r.stage[2]))
    else $error("level changed without stage agreement");
endmodule
`default_nettype wire

// ===== logic/edge_detect.sv
/*
  Rising and falling edge detector on the synchronised comparator level.
  Assumes level is already in the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level and gate
  input wire logic level,
  input wire logic enable,
  // One-cycle edge pulses
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic armed;
    logic prev;
    logic rise;
    logic fall;
  } edge_t;

  edge_t st_r;
  edge_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // Not armed in the first enabled cycle, so enabling is no edge
    st_nxt.armed = enable;
    st_nxt.prev = level;
    st_nxt.rise = enable && st_r.armed && level && !st_r.prev;
    st_nxt.fall = enable && st_r.armed && !level && st_r.prev;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise = st_r.rise;
  assign fall = st_r.fall;

  rise_detect_a: assert property (@(posedge clk) disable iff (rst)
    enable && st_r.armed && level && !st_r.prev |=> rise && !fall)
    else $error("rising edge not reported");
endmodule
`default_nettype wire

// ===== logic/comparator_edge_control.sv
/*
  Comparator control register, edge flags, outputs and wake request,
  with an AXI4-Lite register slave.
  Assumes the analog comparator delivers its decision on CMP_ANALOG_IN
  asynchronously and takes its settings from ANALOG_CFG.
*/
// Design decision made here: the AXI4-Lite slave port.
// Contract
// - Falling output edge sets the falling flag, control bit 4.
// - Rising output edge sets the rising flag, control bit 5.
// - Edge flags stay set until software writes them to zero.
// - Control bit 6 reads the present comparator output level.
// - Control bit 7 enables the comparator when one, disables when zero.
// - Disabled comparator drives its routed outputs low.
// - Enabled comparator with output low wakes the oscillator.
// - Bits 3..2 select positive hysteresis: off, 5, 10, 20 mV.
// - Bits 1..0 select negative hysteresis: off, 5, 10, 20 mV.
// - Latched clocked output plus raw output that needs no clock.
// - Interrupt requests offered on rising and falling transitions.
// - Input select register holds four-bit positive and negative selects.
`timescale 1ns/1ps
`default_nettype none
module comparator_edge_control (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // AXI4-Lite write address
  input wire logic [cmp_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read address
  input wire logic [cmp_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // AXI4-Lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Analog comparator
  input wire logic CMP_ANALOG_IN,
  output cmp_pkg::analog_cfg_t ANALOG_CFG,
  // Comparator outputs
  output logic LATCHED_CMP_OUT,
  output logic RAW_CMP_OUT,
  // System events
  output logic OSC_WAKE,
  output logic RISE_IRQ,
  output logic FALL_IRQ
);
  typedef struct packed {
    logic aw_have;
    logic [cmp_pkg::ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    cmp_pkg::analog_cfg_t cfg;
    logic rise;
    logic fall;
    logic latched;
    logic wake;
    logic rise_irq;
    logic fall_irq;
  } state_t;

  localparam state_t STATE_RESET = '{
    aw_have: 1'b0,
    aw_addr: '0,
    w_have: 1'b0,
    wdata: 8'h00,
    wstrb0: 1'b0,
    awready: 1'b1,
    wready: 1'b1,
    bvalid: 1'b0,
    bresp: cmp_pkg::RESP_OKAY,
    arready: 1'b1,
    rvalid: 1'b0,
    rdata: 8'h00,
    rresp: cmp_pkg::RESP_OKAY,
    cfg: '{
      enable: cmp_pkg::CTRL_RESET[cmp_pkg::EN_BIT],
      pos_hyst: cmp_pkg::hyst_t'(cmp_pkg::CTRL_RESET[cmp_pkg::HYP_LSB +: 2]),
      neg_hyst: cmp_pkg::hyst_t'(cmp_pkg::CTRL_RESET[cmp_pkg::HYN_LSB +: 2]),
      pos_sel: cmp_pkg::MUX_RESET[cmp_pkg::PSEL_LSB +: 4],
      neg_sel: cmp_pkg::MUX_RESET[cmp_pkg::NSEL_LSB +: 4]
    },
    rise: cmp_pkg::CTRL_RESET[cmp_pkg::RISE_BIT],
    fall: cmp_pkg::CTRL_RESET[cmp_pkg::FALL_BIT],
    latched: 1'b0,
    wake: 1'b0,
    rise_irq: 1'b0,
    fall_irq: 1'b0
  };

  state_t st_r;
  state_t st_nxt;

  logic level;
  logic rise_pulse;
  logic fall_pulse;
  logic commit;
  logic ctrl_wr;
  logic mux_wr;
  cmp_pkg::reg_sel_t wr_sel;

  // Word-aligned decode; the low two address bits are ignored
  function automatic cmp_pkg::reg_sel_t addr_sel(input logic [cmp_pkg::ADDR_W-1:0] addr);
    logic [cmp_pkg::ADDR_W-1:0] word;
    word = {addr[cmp_pkg::ADDR_W-1:2], 2'h0};
    if (word == cmp_pkg::CTRL_ADDR) begin
      addr_sel = cmp_pkg::SEL_CTRL;
    end else if (word == cmp_pkg::MUX_ADDR) begin
      addr_sel = cmp_pkg::SEL_MUX;
    end else begin
      addr_sel = cmp_pkg::SEL_NONE;
    end
  endfunction

  function automatic logic [7:0] ctrl_byte(input state_t s);
    ctrl_byte = {s.cfg.enable, s.latched, s.rise, s.fall, s.cfg.pos_hyst, s.cfg.neg_hyst};
  endfunction

  cmp_sync u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .async_in(CMP_ANALOG_IN),
    .level(level)
  );

  edge_detect u_edge (
    .clk(REF_CLK),
    .rst(RST),
    .level(level),
    .enable(st_r.cfg.enable),
    .rise(rise_pulse),
    .fall(fall_pulse)
  );

  // Write happens once address and data are both held
  assign commit = st_r.aw_have && st_r.w_have && !st_r.bvalid;
  assign wr_sel = addr_sel(st_r.aw_addr);
  assign ctrl_wr = commit && st_r.wstrb0 && (wr_sel == cmp_pkg::SEL_CTRL);
  assign mux_wr = commit && st_r.wstrb0 && (wr_sel == cmp_pkg::SEL_MUX);

  always_comb begin
    st_nxt = st_r;
    // Address and data accepted in either order
    if (AWVALID && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = AWADDR;
    end
    if (WVALID && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = WDATA[7:0];
      st_nxt.wstrb0 = WSTRB[0];
    end
    if (st_r.bvalid && BREADY) begin
      st_nxt.bvalid = 1'b0;
    end
    if (commit) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = (wr_sel == cmp_pkg::SEL_NONE) ? cmp_pkg::RESP_DECERR : cmp_pkg::RESP_OKAY;
    end
    // No new write is taken until the response has gone
    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;

    // Read path
    if (st_r.rvalid && RREADY) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ARVALID && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      case (addr_sel(ARADDR))
        cmp_pkg::SEL_CTRL: begin
          st_nxt.rdata = ctrl_byte(st_r);
          st_nxt.rresp = cmp_pkg::RESP_OKAY;
        end
        cmp_pkg::SEL_MUX: begin
          st_nxt.rdata = {st_r.cfg.neg_sel, st_r.cfg.pos_sel};
          st_nxt.rresp = cmp_pkg::RESP_OKAY;
        end
        default: begin
          st_nxt.rdata = 8'h00;
          st_nxt.rresp = cmp_pkg::RESP_DECERR;
        end
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Control register; output state bit is read-only
    if (ctrl_wr) begin
      st_nxt.cfg.enable = st_r.wdata[cmp_pkg::EN_BIT];
      st_nxt.rise = st_r.wdata[cmp_pkg::RISE_BIT];
      st_nxt.fall = st_r.wdata[cmp_pkg::FALL_BIT];
      st_nxt.cfg.pos_hyst = cmp_pkg::hyst_t'(st_r.wdata[cmp_pkg::HYP_LSB +: 2]);
      st_nxt.cfg.neg_hyst = cmp_pkg::hyst_t'(st_r.wdata[cmp_pkg::HYN_LSB +: 2]);
    end
    if (mux_wr) begin
      st_nxt.cfg.pos_sel = st_r.wdata[cmp_pkg::PSEL_LSB +: 4];
      st_nxt.cfg.neg_sel = st_r.wdata[cmp_pkg::NSEL_LSB +: 4];
    end
    // Hardware set overrides a same-cycle software clear
    if (rise_pulse) begin
      st_nxt.rise = 1'b1;
    end
    if (fall_pulse) begin
      st_nxt.fall = 1'b1;
    end

    // Outputs forced low while disabled
    st_nxt.latched = st_nxt.cfg.enable && level;
    st_nxt.wake = st_nxt.cfg.enable && !level;
    st_nxt.rise_irq = rise_pulse;
    st_nxt.fall_irq = fall_pulse;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_r <= STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign AWREADY = st_r.awready;
  assign WREADY = st_r.wready;
  assign BVALID = st_r.bvalid;
  assign BRESP = st_r.bresp;
  assign ARREADY = st_r.arready;
  assign RVALID = st_r.rvalid;
  assign RRESP = st_r.rresp;
  assign RDATA = {24'h000000, st_r.rdata};
  assign ANALOG_CFG = st_r.cfg;
  assign LATCHED_CMP_OUT = st_r.latched;
  assign OSC_WAKE = st_r.wake;
  assign RISE_IRQ = st_r.rise_irq;
  assign FALL_IRQ = st_r.fall_irq;
  // Raw path must work with the clock stopped, so only gated by the enable
  assign RAW_CMP_OUT = CMP_ANALOG_IN && st_r.cfg.enable;

  sequence wr_commit_s;
    commit;
  endsequence

  sequence resp_shown_s;
    BVALID ##0 !AWREADY ##0 !WREADY;
  endsequence

  write_resp_a: assert property (@(posedge REF_CLK) disable iff (RST)
    wr_commit_s |=> resp_shown_s)
    else $error("write response not raised after commit");

  sequence rd_take_s;
    ARVALID && ARREADY;
  endsequence

  sequence rd_shown_s;
    RVALID ##0 !ARREADY;
  endsequence

  read_resp_a: assert property (@(posedge REF_CLK) disable iff (RST)
    rd_take_s |=> rd_shown_s)
    else $error("read data not raised after address");

  fall_flag_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
    fall_pulse |=> st_r.fall && FALL_IRQ)
    else $error("falling edge did not set flag");

  rise_flag_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
    rise_pulse |=> st_r.rise && RISE_IRQ)
    else $error("rising edge did not set flag");

  // Each flag on its own, so one dropping while the other is clear still fires
  flag_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !ctrl_wr |=> (!$past(st_r.rise) || st_r.rise) && (!$past(st_r.fall) || st_r.fall))
    else $error("edge flag cleared without software write");

  state_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
    ARVALID && ARREADY && addr_sel(ARADDR) == cmp_pkg::SEL_CTRL
    |=> RVALID && RDATA[cmp_pkg::OUT_BIT] == $past(LATCHED_CMP_OUT))
    else $error("output state bit wrong on read");

  enable_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
    ctrl_wr |=> ANALOG_CFG.enable == $past(st_r.wdata[cmp_pkg::EN_BIT]))
    else $error("enable bit not taken from write");

  disabled_low_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !ANALOG_CFG.enable |-> !LATCHED_CMP_OUT && !RAW_CMP_OUT && !OSC_WAKE)
    else $error("output not low while disabled");

  osc_wake_a: assert property (@(posedge REF_CLK) disable iff (RST)
    ANALOG_CFG.enable |-> OSC_WAKE == !LATCHED_CMP_OUT)
    else $error("wake does not follow low output");

  hyst_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
    ctrl_wr |=> ANALOG_CFG.pos_hyst == $past(st_r.wdata[cmp_pkg::HYP_LSB +: 2])
      && ANALOG_CFG.neg_hyst == $past(st_r.wdata[cmp_pkg::HYN_LSB +: 2]))
    else $error("hysteresis fields not taken from write");

  irq_pulse_a: assert property (@(posedge REF_CLK) disable iff (RST)
    RISE_IRQ |=> !RISE_IRQ)
    else $error("rise request longer than one cycle");

  input_sel_a: assert property (@(posedge REF_CLK) disable iff (RST)
    mux_wr |=> {ANALOG_CFG.neg_sel, ANALOG_CFG.pos_sel} == $past(st_r.wdata))
    else $error("input select not taken from write");

  set_wins_a: assert property (@(posedge REF_CLK) disable iff (RST)
    fall_pulse && ctrl_wr |=> st_r.fall)
    else $error("software clear beat hardware set");

  fall_irq_pulse_a: assert property (@(posedge REF_CLK) disable iff (RST)
    FALL_IRQ |=> !FALL_IRQ)
    else $error("fall request longer than one cycle");

  flag_clear_a: assert property (@(posedge REF_CLK) disable iff (RST)
    ctrl_wr && !st_r.wdata[cmp_pkg::RISE_BIT] && !rise_pulse |=> !st_r.rise)
    else $error("rise flag not cleared by write");

  ignored_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
    commit && !ctrl_wr && !mux_wr |=> $stable(ANALOG_CFG))
    else $error("refused write changed settings");
endmodule
`default_nettype wire

// ===== test/test_comparator_edge_control.sv
/*
  Self-checking bench for comparator_edge_control: bus access, hysteresis
  and input selects, edge flags, pulses, wake request and output gating.
  Assumes the block alone on a 20 MHz clock, with the bench as bus master.
*/
`timescale 1ns/1ps
`default_nettype none
module test_comparator_edge_control;
  // Clock, reset and stimulus
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [cmp_pkg::ADDR_W-1:0] awaddr = 12'h000;
  logic [cmp_pkg::ADDR_W-1:0] araddr = 12'h000;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic cmp_in = 1'h0;
  // Observed outputs
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  cmp_pkg::analog_cfg_t cfg;
  logic latched, raw, wake, rise_irq, fall_irq;
  int err_count = 0;
  int checked = 0;
  int rise_n = 0;
  int fall_n = 0;

  comparator_edge_control i_comparator_edge_control (
    .REF_CLK(clk), .RST(rst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .CMP_ANALOG_IN(cmp_in), .ANALOG_CFG(cfg),
    .LATCHED_CMP_OUT(latched), .RAW_CMP_OUT(raw),
    .OSC_WAKE(wake), .RISE_IRQ(rise_irq), .FALL_IRQ(fall_irq)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  // Pulses are counted, so a pulse longer than one cycle shows up
  always @(posedge clk) begin
    if (rise_irq === 1'h1) rise_n <= rise_n + 1;
    if (fall_irq === 1'h1) fall_n <= fall_n + 1;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic timed_out();
    err_count++;
    $display("bus handshake wait ran out");
    give_verdict();
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                           input logic [1:0] exp_resp);
    int n;
    logic [1:0] resp;
    n = 0;
    resp = 2'h1;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= {24'h000000, d};
    wstrb <= s;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (n < 100) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        resp = bresp;
        break;
      end
    end
    bready <= 1'h0;
    if (n >= 100) timed_out();
    check("write response", {30'h0, resp}, {30'h0, exp_resp});
  endtask

  // Reads one register and compares data and response
  task automatic read_check(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (n < 100) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        check("read data", rdata, {24'h000000, exp});
        check("read response", {30'h0, rresp}, {30'h0, er});
        break;
      end
    end
    rready <= 1'h0;
    if (n >= 100) timed_out();
  endtask

  // Edge pulses need sync, edge and flag stages, so ten cycles suffice
  task automatic settle();
    repeat (10) @(posedge clk);
  endtask

  task automatic reset_values();
    read_check(cmp_pkg::CTRL_ADDR, 8'h00, cmp_pkg::RESP_OKAY);
    read_check(cmp_pkg::MUX_ADDR, 8'h00, cmp_pkg::RESP_OKAY);
    check("latched out", {31'h0, latched}, 32'h0);
    check("raw out", {31'h0, raw}, 32'h0);
  endtask

  task automatic config_fields();
    logic [1:0] p;
    for (int i = 0; i < 4; i++) begin
      p = 2'(i);
      axi_write(cmp_pkg::CTRL_ADDR, {4'h0, p, ~p}, 4'h1, cmp_pkg::RESP_OKAY);
      check("pos hyst", {30'h0, cfg.pos_hyst}, {30'h0, p});
      check("neg hyst", {30'h0, cfg.neg_hyst}, {30'h0, ~p});
      read_check(cmp_pkg::CTRL_ADDR, {4'h0, p, ~p}, cmp_pkg::RESP_OKAY);
    end
    axi_write(cmp_pkg::MUX_ADDR, 8'ha5, 4'h1, cmp_pkg::RESP_OKAY);
    check("pos select", {28'h0, cfg.pos_sel}, 32'h5);
    check("neg select", {28'h0, cfg.neg_sel}, 32'ha);
    read_check(cmp_pkg::MUX_ADDR, 8'ha5, cmp_pkg::RESP_OKAY);
    // Output state bit ignores writes
    axi_write(cmp_pkg::CTRL_ADDR, 8'h40, 4'h1, cmp_pkg::RESP_OKAY);
    read_check(cmp_pkg::CTRL_ADDR, 8'h00, cmp_pkg::RESP_OKAY);
  endtask

  // Reset in mid-run must bring the select register back as well
  task automatic mid_reset();
    @(posedge clk);
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    reset_values();
  endtask

  task automatic bus_refusals();
    axi_write(12'h100, 8'hff, 4'h1, cmp_pkg::RESP_DECERR);
    read_check(12'h100, 8'h00, cmp_pkg::RESP_DECERR);
    axi_write(cmp_pkg::CTRL_ADDR, 8'h83, 4'h0, cmp_pkg::RESP_OKAY);
    read_check(cmp_pkg::CTRL_ADDR, 8'h00, cmp_pkg::RESP_OKAY);
  endtask

  task automatic edges_and_gating();
    @(posedge clk);
    cmp_in <= 1'h1;
    settle();
    check("raw disabled", {31'h0, raw}, 32'h0);
    check("latched disabled", {31'h0, latched}, 32'h0);
    check("wake disabled", {31'h0, wake}, 32'h0);
    axi_write(cmp_pkg::CTRL_ADDR, 8'h80, 4'h1, cmp_pkg::RESP_OKAY);
    check("cfg enable", {31'h0, cfg.enable}, 32'h1);
    settle();
    check("latched high", {31'h0, latched}, 32'h1);
    check("wake while high", {31'h0, wake}, 32'h0);
    read_check(cmp_pkg::CTRL_ADDR, 8'hc0, cmp_pkg::RESP_OKAY);
    check("raw enabled", {31'h0, raw}, 32'h1);
    @(posedge clk);
    cmp_in <= 1'h0;
    #1;
    check("raw follows at once", {31'h0, raw}, 32'h0);
    settle();
    check("fall pulses", 32'(fall_n), 32'h1);
    check("wake while low", {31'h0, wake}, 32'h1);
    read_check(cmp_pkg::CTRL_ADDR, 8'h90, cmp_pkg::RESP_OKAY);
    @(posedge clk);
    cmp_in <= 1'h1;
    settle();
    check("rise pulses", 32'(rise_n), 32'h1);
    read_check(cmp_pkg::CTRL_ADDR, 8'hf0, cmp_pkg::RESP_OKAY);
    repeat (30) @(posedge clk);
    read_check(cmp_pkg::CTRL_ADDR, 8'hf0, cmp_pkg::RESP_OKAY);
    // Bench clears both flags in the retuning write, as software should
    axi_write(cmp_pkg::CTRL_ADDR, 8'h85, 4'h1, cmp_pkg::RESP_OKAY);
    read_check(cmp_pkg::CTRL_ADDR, 8'hc5, cmp_pkg::RESP_OKAY);
    // Clear commits in the very cycle the falling edge sets its flag
    @(posedge clk);
    cmp_in <= 1'h0;
    repeat (3) @(posedge clk);
    axi_write(cmp_pkg::CTRL_ADDR, 8'h85, 4'h1, cmp_pkg::RESP_OKAY);
    read_check(cmp_pkg::CTRL_ADDR, 8'h95, cmp_pkg::RESP_OKAY);
    check("fall pulses again", 32'(fall_n), 32'h2);
    @(posedge clk);
    cmp_in <= 1'h1;
    settle();
    check("rise pulses again", 32'(rise_n), 32'h2);
    read_check(cmp_pkg::CTRL_ADDR, 8'hf5, cmp_pkg::RESP_OKAY);
    axi_write(cmp_pkg::CTRL_ADDR, 8'h00, 4'h1, cmp_pkg::RESP_OKAY);
    settle();
    check("latched off", {31'h0, latched}, 32'h0);
    check("raw off", {31'h0, raw}, 32'h0);
    check("no pulse on disable", 32'(fall_n), 32'h2);
    check("no rise on disable", 32'(rise_n), 32'h2);
    read_check(cmp_pkg::CTRL_ADDR, 8'h00, cmp_pkg::RESP_OKAY);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    reset_values();
    config_fields();
    bus_refusals();
    mid_reset();
    edges_and_gating();
    give_verdict();
  end
endmodule
`default_nettype wire
